/* rtl/pmx_shaper.sv */
// Mode switching, aux wave, edge builder, output combiner and rectifier timing
`timescale 1ns/1ps
`include "pmx_cfg.svh"

// Function
// - Firmware enables auto mode switching with one or two levels: base, mid, high.
// - With auto switching on, filter duty picks the active configuration set.
// - Four thresholds, two rise/fall pairs, give hysteresis at each switch point.
// - Base to mid above low rising threshold; back only below low falling one.
// - Each engine has an aux wave rising at blank begin, falling at blank end.
// - Edge builder uses own and next engine A/B; engine 3's next is 0.
// - Each of four built edges picks one of eight source edges by 3 bits.
// - Codes 0-3 own A rise/fall, B rise/fall; 4-7 same for next engine.
// - Combiner selects come from the active configuration set.
// - A select: own A, built A, own aux, own B, next A/B, aux n+1..n+3.
// - B select: own B, built B, own aux, own A, next A/B, aux n+1..n+3.
// - With combiner off, outputs are the engine's own shaped A and B.
// - Engine indices in the combiner wrap modulo four.
// - Cycle-by-cycle limit ends the A pulse at once when the comparator trips.
// - Option limits B width to the truncated A width.
// - Base set is multi width, mid resonant, high caps rectifier on-time at sr_fix.
// - Rectifier drive off until output nominal, then ramps up slowly.
// - In discontinuous mode with diode emulation on, on-time is capped at the Vin, Vout and duty value; in the high set sr_fix wins once the ramp exceeds it.
module pmx_shaper #(
  parameter int NENG = 4,
  parameter int CW = 16
) (
  input wire logic clk_i,
  input wire logic srst_i,
  input wire logic ce_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [11:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  input wire logic [15:0] duty_i,
  input wire logic [NENG-1:0] eng_a_i,
  input wire logic [NENG-1:0] eng_b_i,
  input wire logic [NENG-1:0] period_start_i,
  input wire logic [NENG*CW-1:0] eng_cnt_i,
  input wire logic [NENG-1:0] cbc_trip_i,
  input wire logic out_nominal_i,
  output logic [NENG-1:0] pwm_out_a_o,
  output logic [NENG-1:0] pwm_out_b_o,
  output pmx_pkg::pmx_set_e active_set_o,
  output pmx_pkg::pmx_conv_e conv_mode_o,
  output logic [15:0] sr_on_time_o
);
  import pmx_pkg::*;

  logic [31:0] ctrl;
  logic [31:0] thr_low;
  logic [31:0] thr_high;
  logic [31:0] blank;
  logic [31:0] edge_sel;
  logic [31:0] cfg_base;
  logic [31:0] cfg_mid;
  logic [31:0] cfg_high;
  logic [31:0] vin;
  logic [31:0] vout;
  logic [31:0] sr_cfg;
  logic [31:0] sr_fix;
  logic [15:0] ide_time;
  logic [15:0] sr_ramp;
  pmx_set_e set_q;
  pmx_set_e next_set;
  logic [31:0] cfg_act;
  logic [NENG-1:0] a_s;
  logic [NENG-1:0] b_s;
  logic [NENG-1:0] c_w;
  logic [NENG-1:0] ea;
  logic [NENG-1:0] eb;
  logic [NENG-1:0] a_q;
  logic [NENG-1:0] b_q;
  logic acc;
  logic wr_go;
  logic [31:0] rd_val;

  // APB handshake: one wait state, effect on the edge that sees pready
  assign acc = psel_i & penable_i;
  assign wr_go = acc & pready_o & pwrite_i;

  // Read mux; unmapped addresses read zero and flag an error
  always_comb begin
    rd_val = 32'h0000_0000;
    if (paddr_i == `PMX_OFS_CTRL) begin
      rd_val = ctrl;
    end else if (paddr_i == `PMX_OFS_THR_LOW) begin
      rd_val = thr_low;
    end else if (paddr_i == `PMX_OFS_THR_HIGH) begin
      rd_val = thr_high;
    end else if (paddr_i == `PMX_OFS_BLANK) begin
      rd_val = blank;
    end else if (paddr_i == `PMX_OFS_EDGE) begin
      rd_val = edge_sel;
    end else if (paddr_i == `PMX_OFS_CFG_BASE) begin
      rd_val = cfg_base;
    end else if (paddr_i == `PMX_OFS_CFG_MID) begin
      rd_val = cfg_mid;
    end else if (paddr_i == `PMX_OFS_CFG_HIGH) begin
      rd_val = cfg_high;
    end else if (paddr_i == `PMX_OFS_VIN) begin
      rd_val = vin;
    end else if (paddr_i == `PMX_OFS_VOUT) begin
      rd_val = vout;
    end else if (paddr_i == `PMX_OFS_SR_CFG) begin
      rd_val = sr_cfg;
    end else if (paddr_i == `PMX_OFS_SR_FIX) begin
      rd_val = sr_fix;
    end else if (paddr_i == `PMX_OFS_STATUS) begin
      rd_val = {12'h000, conv_mode_o, active_set_o, sr_on_time_o};
    end else if (paddr_i == `PMX_OFS_IDE) begin
      rd_val = {16'h0000, ide_time};
    end
  end

  // Bus answer registers
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      pready_o <= 1'b0;
      prdata_o <= 32'h0000_0000;
      pslverr_o <= 1'b0;
    end else if (ce_i) begin
      pready_o <= acc & ~pready_o;
      if (acc & ~pready_o) begin
        prdata_o <= pwrite_i ? 32'h0000_0000 : rd_val;
        pslverr_o <= (paddr_i > `PMX_OFS_IDE) | (paddr_i[1:0] != 2'b00);
      end
    end
  end

  // Writable registers; status and results are read only
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      ctrl <= `PMX_RST_CTRL;
      thr_low <= `PMX_RST_THR;
      thr_high <= `PMX_RST_THR;
      blank <= `PMX_RST_CFG;
      edge_sel <= `PMX_RST_EDGE;
      cfg_base <= `PMX_RST_CFG;
      cfg_mid <= `PMX_RST_CFG;
      cfg_high <= `PMX_RST_CFG;
      vin <= `PMX_RST_CFG;
      vout <= `PMX_RST_CFG;
      sr_cfg <= `PMX_RST_CFG;
      sr_fix <= `PMX_RST_CFG;
    end else if (ce_i & wr_go) begin
      if (paddr_i == `PMX_OFS_CTRL) begin
        ctrl <= pwdata_i;
      end else if (paddr_i == `PMX_OFS_THR_LOW) begin
        thr_low <= pwdata_i;
      end else if (paddr_i == `PMX_OFS_THR_HIGH) begin
        thr_high <= pwdata_i;
      end else if (paddr_i == `PMX_OFS_BLANK) begin
        blank <= pwdata_i;
      end else if (paddr_i == `PMX_OFS_EDGE) begin
        edge_sel <= pwdata_i;
      end else if (paddr_i == `PMX_OFS_CFG_BASE) begin
        cfg_base <= pwdata_i;
      end else if (paddr_i == `PMX_OFS_CFG_MID) begin
        cfg_mid <= pwdata_i;
      end else if (paddr_i == `PMX_OFS_CFG_HIGH) begin
        cfg_high <= pwdata_i;
      end else if (paddr_i == `PMX_OFS_VIN) begin
        vin <= pwdata_i;
      end else if (paddr_i == `PMX_OFS_VOUT) begin
        vout <= pwdata_i;
      end else if (paddr_i == `PMX_OFS_SR_CFG) begin
        sr_cfg <= pwdata_i;
      end else if (paddr_i == `PMX_OFS_SR_FIX) begin
        sr_fix <= pwdata_i;
      end
    end
  end

  // Hysteretic set selection; one step per period keeps changes gentle while auto is on, auto off returns straight to base
  always_comb begin
    next_set = set_q;
    if (!ctrl[`PMX_CTRL_AUTO]) begin
      next_set = PMX_SET_BASE;
    end else begin
      case (set_q)
        PMX_SET_BASE: begin
          if (duty_i > thr_low[15:0]) begin
            next_set = PMX_SET_MID;
          end
        end
        PMX_SET_MID: begin
          if (duty_i < thr_low[31:16]) begin
            next_set = PMX_SET_BASE;
          end else if (ctrl[`PMX_CTRL_TWO_LVL] &&
                       duty_i > thr_high[15:0]) begin
            next_set = PMX_SET_HIGH;
          end
        end
        PMX_SET_HIGH: begin
          if (duty_i < thr_high[31:16] || !ctrl[`PMX_CTRL_TWO_LVL]) begin
            next_set = PMX_SET_MID;
          end
        end
        default: next_set = PMX_SET_BASE;
      endcase
    end
  end

  // Active set only moves at engine 0 period start
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      set_q <= PMX_SET_BASE;
    end else if (ce_i && period_start_i[0]) begin
      set_q <= next_set;
    end
  end

  // Configuration word of the active set
  always_comb begin
    case (set_q)
      PMX_SET_MID: cfg_act = cfg_mid;
      PMX_SET_HIGH: cfg_act = cfg_high;
      default: cfg_act = cfg_base;
    endcase
  end

  // Edge history of shaped A and B for the edge builder
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      a_q <= '0;
      b_q <= '0;
    end else if (ce_i) begin
      a_q <= a_s;
      b_q <= b_s;
    end
  end

  // Per-engine shaping
  for (genvar g = 0; g < NENG; g++) begin : g_eng
    localparam int N1 = (g + 1) % NENG;
    localparam int N2 = (g + 2) % NENG;
    localparam int N3 = (g + 3) % NENG;
    logic cut;
    logic a_prev;
    logic [15:0] a_cnt;
    logic [15:0] a_wid;
    logic [15:0] b_cnt;
    logic [7:0] edges;
    logic [`PMX_SEL_W-1:0] sel_a;
    logic [`PMX_SEL_W-1:0] sel_b;
    logic ma;
    logic mb;
    logic [CW-1:0] cnt;

    assign cnt = eng_cnt_i[g*CW +: CW];

    // Limit trip ends A until the next period start
    always_ff @(posedge clk_i) begin
      if (srst_i) begin
        cut <= 1'b0;
      end else if (ce_i) begin
        if (period_start_i[g]) begin
          cut <= 1'b0;
        end else if (ctrl[`PMX_CTRL_CBC] & eng_a_i[g] & cbc_trip_i[g]) begin
          cut <= 1'b1;
        end
      end
    end

    // Width of truncated A, then B is held to it when matching
    always_ff @(posedge clk_i) begin
      if (srst_i) begin
        a_prev <= 1'b0;
        a_cnt <= 16'h0000;
        a_wid <= 16'hFFFF;
        b_cnt <= 16'h0000;
      end else if (ce_i) begin
        a_prev <= a_s[g];
        if (a_s[g]) begin
          a_cnt <= a_cnt + 16'h0001;
        end else if (a_prev) begin
          a_wid <= a_cnt;
          a_cnt <= 16'h0000;
        end
        b_cnt <= eng_b_i[g] ? b_cnt + 16'h0001 : 16'h0000;
      end
    end

    // Trip is gated in the same cycle so the pulse ends at once
    assign a_s[g] = eng_a_i[g] & ~cut & ~(ctrl[`PMX_CTRL_CBC] &
                    cbc_trip_i[g]);
    assign b_s[g] = eng_b_i[g] & (~ctrl[`PMX_CTRL_MATCH] |
                    (b_cnt < a_wid));

    // Aux wave between blank begin and blank end
    always_ff @(posedge clk_i) begin
      if (srst_i) begin
        c_w[g] <= 1'b0;
      end else if (ce_i) begin
        if (cnt == blank[15:0]) begin
          c_w[g] <= 1'b1;
        end else if (cnt == blank[31:16]) begin
          c_w[g] <= 1'b0;
        end
      end
    end

    // Eight candidate edges, own engine first then next
    assign edges = {b_q[N1] & ~b_s[N1], ~b_q[N1] & b_s[N1],
                    a_q[N1] & ~a_s[N1], ~a_q[N1] & a_s[N1],
                    b_q[g] & ~b_s[g], ~b_q[g] & b_s[g],
                    a_q[g] & ~a_s[g], ~a_q[g] & a_s[g]};

    // Built outputs set and clear on their chosen edges
    always_ff @(posedge clk_i) begin
      if (srst_i) begin
        ea[g] <= 1'b0;
        eb[g] <= 1'b0;
      end else if (ce_i) begin
        if (edges[edge_sel[2:0]]) begin
          ea[g] <= 1'b1;
        end else if (edges[edge_sel[5:3]]) begin
          ea[g] <= 1'b0;
        end
        if (edges[edge_sel[8:6]]) begin
          eb[g] <= 1'b1;
        end else if (edges[edge_sel[11:9]]) begin
          eb[g] <= 1'b0;
        end
      end
    end

    // Selects latched at this engine's own period start
    always_ff @(posedge clk_i) begin
      if (srst_i) begin
        sel_a <= '0;
        sel_b <= '0;
      end else if (ce_i && period_start_i[g]) begin
        sel_a <= cfg_act[g*8 +: 4];
        sel_b <= cfg_act[g*8+4 +: 4];
      end
    end

    // Source decode; codes above 8 fall back to pass-through
    always_comb begin
      case (sel_a)
        4'h1: ma = ea[g];
        4'h2: ma = c_w[g];
        4'h3: ma = b_s[g];
        4'h4: ma = a_s[N1];
        4'h5: ma = b_s[N1];
        4'h6: ma = c_w[N1];
        4'h7: ma = c_w[N2];
        4'h8: ma = c_w[N3];
        default: ma = a_s[g];
      endcase
      case (sel_b)
        4'h1: mb = eb[g];
        4'h2: mb = c_w[g];
        4'h3: mb = a_s[g];
        4'h4: mb = a_s[N1];
        4'h5: mb = b_s[N1];
        4'h6: mb = c_w[N1];
        4'h7: mb = c_w[N2];
        4'h8: mb = c_w[N3];
        default: mb = b_s[g];
      endcase
    end

    // Outputs registered; fine edge placement is not used here
    always_ff @(posedge clk_i) begin
      if (srst_i) begin
        pwm_out_a_o[g] <= 1'b0;
        pwm_out_b_o[g] <= 1'b0;
      end else if (ce_i) begin
        pwm_out_a_o[g] <= ctrl[`PMX_CTRL_COMB] ? ma : a_s[g];
        pwm_out_b_o[g] <= ctrl[`PMX_CTRL_COMB] ? mb : b_s[g];
      end
    end
  end

  // Diode emulation: on-time = duty*(vin-vout)/vout, serial divide
  logic [31:0] ide_rem;
  logic [31:0] ide_quo;
  logic [5:0] ide_steps;
  logic [32:0] ide_tr;
  logic [15:0] vdiff;
  assign vdiff = (vin[15:0] > vout[15:0]) ? vin[15:0] - vout[15:0] : 16'h0000;
  assign ide_tr = {ide_rem, ide_quo[31]};

  // A divide takes 32 cycles; the next starts at the first engine 0 period
  // after it ends, so periods shorter than the divide still get a result
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      ide_rem <= 32'h0000_0000;
      ide_quo <= 32'h0000_0000;
      ide_steps <= 6'h00;
      ide_time <= 16'h0000;
    end else if (ce_i) begin
      if (ide_steps != 6'h00) begin
        ide_steps <= ide_steps - 6'h01;
        if (ide_tr >= {17'h00000, vout[15:0]}) begin
          ide_rem <= 32'(ide_tr - {17'h00000, vout[15:0]});
          ide_quo <= {ide_quo[30:0], 1'b1};
        end else begin
          ide_rem <= ide_tr[31:0];
          ide_quo <= {ide_quo[30:0], 1'b0};
        end
        // Bit 31 still holds dividend, so saturation looks at 30:15
        if (ide_steps == 6'h01) begin
          ide_time <= (ide_quo[30:15] != 16'h0000) ? 16'hFFFF :
                      {ide_quo[14:0], ide_tr >= {17'h00000, vout[15:0]}};
        end
      end else if (period_start_i[0] && ctrl[`PMX_CTRL_IDE]) begin
        ide_rem <= 32'h0000_0000;
        ide_quo <= 32'(duty_i) * 32'(vdiff);
        ide_steps <= `PMX_IDE_STEPS;
      end
    end
  end

  // Rectifier soft-on: zero until nominal, then steps once every sr_cfg[31:24]+1 periods
  logic [7:0] ramp_div;
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      sr_ramp <= 16'h0000;
      ramp_div <= 8'h00;
    end else if (ce_i) begin
      if (!ctrl[`PMX_CTRL_SR_RAMP] || !out_nominal_i) begin
        sr_ramp <= 16'h0000;
        ramp_div <= 8'h00;
      end else if (period_start_i[0]) begin
        if (ramp_div >= sr_cfg[31:24]) begin
          ramp_div <= 8'h00;
          if ({1'b0, sr_ramp} + {9'h000, sr_cfg[23:16]} >=
              {1'b0, sr_cfg[15:0]}) begin
            sr_ramp <= sr_cfg[15:0];
          end else begin
            sr_ramp <= sr_ramp + {8'h00, sr_cfg[23:16]};
          end
        end else begin
          ramp_div <= ramp_div + 8'h01;
        end
      end
    end
  end

  // Final on-time and conversion mode follow the active set
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      sr_on_time_o <= 16'h0000;
      conv_mode_o <= PMX_CONV_MULTI;
      active_set_o <= PMX_SET_BASE;
    end else if (ce_i) begin
      active_set_o <= set_q;
      case (set_q)
        PMX_SET_MID: conv_mode_o <= PMX_CONV_RESON;
        PMX_SET_HIGH: conv_mode_o <= PMX_CONV_FIXSR;
        default: conv_mode_o <= PMX_CONV_MULTI;
      endcase
      if (set_q == PMX_SET_HIGH && sr_ramp > sr_fix[15:0]) begin
        sr_on_time_o <= sr_fix[15:0];
      end else if (ctrl[`PMX_CTRL_IDE] && ctrl[`PMX_CTRL_DCM] &&
                   ide_time < sr_ramp) begin
        sr_on_time_o <= ide_time;
      end else begin
        sr_on_time_o <= sr_ramp;
      end
    end
  end
endmodule

/* rtl/pmx_cfg.svh */
// Register offsets, field positions and reset values of the output shaper
`ifndef PMX_CFG_SVH
`define PMX_CFG_SVH
`define PMX_OFS_CTRL 12'h000
`define PMX_OFS_THR_LOW 12'h004
`define PMX_OFS_THR_HIGH 12'h008
`define PMX_OFS_BLANK 12'h00C
`define PMX_OFS_EDGE 12'h010
`define PMX_OFS_CFG_BASE 12'h014
`define PMX_OFS_CFG_MID 12'h018
`define PMX_OFS_CFG_HIGH 12'h01C
`define PMX_OFS_VIN 12'h020
`define PMX_OFS_VOUT 12'h024
`define PMX_OFS_SR_CFG 12'h028
`define PMX_OFS_SR_FIX 12'h02C
`define PMX_OFS_STATUS 12'h030
`define PMX_OFS_IDE 12'h034
`define PMX_CTRL_AUTO 0
`define PMX_CTRL_TWO_LVL 1
`define PMX_CTRL_COMB 2
`define PMX_CTRL_CBC 3
`define PMX_CTRL_MATCH 4
`define PMX_CTRL_SR_RAMP 5
`define PMX_CTRL_IDE 6
`define PMX_CTRL_DCM 7
`define PMX_RST_CTRL 32'h0000_0000
`define PMX_RST_THR 32'h0000_0000
`define PMX_RST_CFG 32'h0000_0000
`define PMX_RST_EDGE 32'h0000_0000
`define PMX_SEL_W 4
`define PMX_EDGE_W 3
`define PMX_IDE_STEPS 6'h20
`endif

/* rtl/pmx_pkg.sv */
// Types shared by the output shaper and its bench
package pmx_pkg;
  typedef enum logic [1:0] {PMX_SET_BASE, PMX_SET_MID, PMX_SET_HIGH} pmx_set_e;
  typedef enum logic [1:0] {PMX_CONV_MULTI, PMX_CONV_RESON, PMX_CONV_FIXSR}
    pmx_conv_e;
endpackage

/* verif/pmx_shaper_properties.sv */
// Port-level assertions of the output shaper
`timescale 1ns/1ps
module pmx_shaper_checker #(
  parameter int NENG = 4,
  parameter int CW = 16
) (
  input wire logic clk_i,
  input wire logic srst_i,
  input wire logic ce_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [11:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  input wire logic [31:0] prdata_o,
  input wire logic pready_o,
  input wire logic pslverr_o,
  input wire logic [15:0] duty_i,
  input wire logic [NENG-1:0] eng_a_i,
  input wire logic [NENG-1:0] eng_b_i,
  input wire logic [NENG-1:0] period_start_i,
  input wire logic [NENG*CW-1:0] eng_cnt_i,
  input wire logic [NENG-1:0] cbc_trip_i,
  input wire logic out_nominal_i,
  input wire logic [NENG-1:0] pwm_out_a_o,
  input wire logic [NENG-1:0] pwm_out_b_o,
  input wire pmx_pkg::pmx_set_e active_set_o,
  input wire pmx_pkg::pmx_conv_e conv_mode_o,
  input wire logic [15:0] sr_on_time_o
);
  import pmx_pkg::*;
  logic [31:0] ctrl;
  logic [15:0] rise_lo;
  logic [5:0] quiet;
  logic wr;
  assign wr = psel_i & penable_i & pready_o & pwrite_i;
  // Control shadow; quiet saturates so settled windows can be told apart
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      ctrl <= '0;
      quiet <= '0;
    end else if (wr && paddr_i == 12'h000) begin
      ctrl <= pwdata_i;
      quiet <= '0;
    end else if (quiet != 6'h3F) begin
      quiet <= quiet + 6'h01;
    end
  end
  // Low rising threshold as last written
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      rise_lo <= '0;
    end else if (wr && paddr_i == 12'h004) begin
      rise_lo <= pwdata_i[15:0];
    end
  end
  default clocking @(posedge clk_i);
  endclocking
  default disable iff (srst_i);
  chk_pass_a: assert property (
    quiet == 6'h3F && ctrl[4:2] == 3'h0 |=> pwm_out_a_o == $past(eng_a_i))
    else $error("A output differs from engine A");
  chk_pass_b: assert property (
    quiet == 6'h3F && ctrl[4:2] == 3'h0 |=> pwm_out_b_o == $past(eng_b_i))
    else $error("B output differs from engine B");
  chk_set_boundary: assert property (
    $changed(active_set_o) |-> $past(period_start_i[0], 2))
    else $error("set changed off a period boundary");
  chk_set_one_step: assert property (
    active_set_o == PMX_SET_HIGH |-> $past(active_set_o) != PMX_SET_BASE)
    else $error("set skipped the mid level");
  chk_mid_rise: assert property (
    $past(active_set_o) == PMX_SET_BASE && active_set_o == PMX_SET_MID
      |-> $past(duty_i, 2) > $past(rise_lo, 2))
    else $error("mid entered without passing the threshold");
  chk_conv_mid: assert property (
    (active_set_o == PMX_SET_MID) [*2] |-> conv_mode_o == PMX_CONV_RESON)
    else $error("mid set not in resonant mode");
  chk_cbc_cut: assert property (
    quiet > 6'h14 && ctrl[3] && !ctrl[2] && cbc_trip_i[0]
      |=> !pwm_out_a_o[0])
    else $error("A pulse not ended on trip");
  chk_sr_held: assert property (
    quiet > 6'h14 && ctrl[5] && !ctrl[6] && !$past(out_nominal_i)
      && !$past(out_nominal_i, 2) |-> sr_on_time_o == 16'h0000)
    else $error("rectifier on before nominal");
endmodule
bind pmx_shaper pmx_shaper_checker #(.NENG(NENG), .CW(CW)) i_chk (.*);

/* verif/pmx_stage_model.sv */
// Behavioural engines of the power stage feeding the shaper
`timescale 1ns/1ps
module pmx_stage_model #(
  parameter int NENG = 4,
  parameter int CW = 16,
  parameter int PER = 16
) (
  input wire logic clk_i,
  input wire logic srst_i,
  output logic [NENG-1:0] eng_a_o,
  output logic [NENG-1:0] eng_b_o,
  output logic [NENG-1:0] period_start_o,
  output logic [NENG*CW-1:0] eng_cnt_o
);
  int cnt = 0;
  function automatic int loc(input int g);
    return (cnt + g * PER / 4) % PER;
  endfunction
  // Shared time base, restarted by reset
  always @(posedge clk_i) begin
    cnt <= (srst_i || cnt == PER - 1) ? 0 : cnt + 1;
  end
  // Engines spread by a quarter period; dead time between A and B
  always_comb begin
    for (int g = 0; g < NENG; g++) begin
      eng_cnt_o[g*CW +: CW] = CW'(loc(g));
      eng_a_o[g] = loc(g) < 6;
      eng_b_o[g] = loc(g) >= 8 && loc(g) < 14;
      period_start_o[g] = loc(g) == 0;
    end
  end
endmodule

/* verif/pmx_shaper_tb.sv */
// Directed bench for the output shaper
`timescale 1ns/1ps
`include "pmx_cfg.svh"
module pmx_shaper_tb;
  import pmx_pkg::*;
  localparam int NENG = 4;
  localparam int CW = 16;
  logic clk_i = 1'b0;
  logic srst_i = 1'b1;
  logic ce_i = 1'b1;
  logic psel_i = 1'b0;
  logic penable_i = 1'b0;
  logic pwrite_i = 1'b0;
  logic [11:0] paddr_i = 12'h000;
  logic [31:0] pwdata_i = 32'h0000_0000;
  logic [15:0] duty_i = 16'h1000;
  logic [3:0] cbc_trip_i = 4'h0;
  logic out_nominal_i = 1'b0;
  logic [31:0] prdata_o;
  logic pready_o;
  logic pslverr_o;
  logic [3:0] eng_a_i;
  logic [3:0] eng_b_i;
  logic [3:0] period_start_i;
  logic [63:0] eng_cnt_i;
  logic [3:0] pwm_out_a_o;
  logic [3:0] pwm_out_b_o;
  pmx_set_e active_set_o;
  pmx_conv_e conv_mode_o;
  logic [15:0] sr_on_time_o;
  logic [31:0] rd;
  logic err;
  logic [4:0] wa;
  logic [4:0] wb;
  int n_mismatch = 0;
  int check_count = 0;
  int cyc = 0;
  logic [15:0] dv [6] = '{16'h5000, 16'h3000, 16'h9000, 16'h7000,
    16'h5000, 16'h1000};
  pmx_set_e sv [6] = '{PMX_SET_MID, PMX_SET_MID, PMX_SET_HIGH,
    PMX_SET_HIGH, PMX_SET_MID, PMX_SET_BASE};
  pmx_shaper #(.NENG(NENG), .CW(CW)) i_dut (.*);
  pmx_stage_model #(.NENG(NENG), .CW(CW)) i_stage (
    .clk_i, .srst_i, .eng_a_o(eng_a_i), .eng_b_o(eng_b_i),
    .period_start_o(period_start_i), .eng_cnt_o(eng_cnt_i));
  always #12.5 clk_i = ~clk_i;
  // Cycle ceiling cuts a hung handshake short
  always @(posedge clk_i) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      n_mismatch = n_mismatch + 1;
      results();
    end
  end
  task automatic results;
    $display("checks %0d mismatches %0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  task automatic cmp(input string what, input logic [31:0] exp,
                     input logic [31:0] got);
    check_count++;
    if (got !== exp) begin
      n_mismatch++;
      $display("ERROR %s expected %0h seen %0h", what, exp, got);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk_i);
  endtask
  // One APB transfer; the request is held until pready is sampled
  task automatic apb(input bit w, input logic [11:0] a,
                     input logic [31:0] d);
    @(posedge clk_i);
    psel_i <= 1'b1;
    pwrite_i <= w;
    paddr_i <= a;
    pwdata_i <= d;
    @(posedge clk_i);
    penable_i <= 1'b1;
    do @(posedge clk_i); while (pready_o !== 1'b1);
    rd = prdata_o;
    err = pslverr_o;
    psel_i <= 1'b0;
    penable_i <= 1'b0;
  endtask
  // Outputs must follow the inputs seen one edge earlier
  task automatic sample(input bit mapped);
    logic [3:0] pa;
    logic [3:0] pb;
    repeat (24) begin
      @(posedge clk_i);
      pa = eng_a_i;
      pb = eng_b_i;
      #1;
      if (mapped) begin
        cmp("mux a", 32'({pa[0], pb[3], pa[2], pb[0]}), 32'(pwm_out_a_o));
        cmp("mux b", 32'({pb[0], pa[3], pb[1], pa[0]}), 32'(pwm_out_b_o));
      end else begin
        cmp("own a", 32'(pa), 32'(pwm_out_a_o));
        cmp("own b", 32'(pb), 32'(pwm_out_b_o));
      end
    end
  endtask
  // High time over one whole period; any 16 cycles hold exactly one
  task automatic width(input int ga, input int gb, input int trip);
    wa = 5'h00;
    wb = 5'h00;
    for (int k = 0; k < 16; k++) begin
      @(posedge clk_i);
      cbc_trip_i[0] <= (k == trip);
      #1;
      wa = wa + 5'(pwm_out_a_o[ga]);
      wb = wb + 5'(pwm_out_b_o[gb]);
    end
  endtask
  initial begin
    repeat (12) @(posedge clk_i);
    srst_i <= 1'b0;
    apb(0, `PMX_OFS_CTRL, 32'h0);
    cmp("ctrl reset", `PMX_RST_CTRL, rd);
    apb(0, 12'h038, 32'h0);
    cmp("unmapped err", 32'h1, 32'(err));
    cmp("unmapped data", 32'h0, rd);
    sample(0);
    $display("test registers and pass-through done");
    apb(1, `PMX_OFS_THR_LOW, 32'h2000_4000);
    apb(1, `PMX_OFS_THR_HIGH, 32'h6000_8000);
    apb(1, `PMX_OFS_CTRL, 32'h0000_0003);
    foreach (dv[i]) begin
      duty_i <= dv[i];
      tick(48);
      cmp("set", 32'(sv[i]), 32'(active_set_o));
      cmp("conv", 32'(sv[i]), 32'(conv_mode_o));
    end
    $display("test mode switching done");
    apb(1, `PMX_OFS_CFG_BASE, 32'h5445_0433);
    apb(1, `PMX_OFS_CTRL, 32'h0000_0004);
    tick(40);
    sample(1);
    apb(1, `PMX_OFS_CFG_MID, 32'h0);
    apb(1, `PMX_OFS_CTRL, 32'h0000_0007);
    duty_i <= 16'h5000;
    tick(48);
    sample(0);
    duty_i <= 16'h1000;
    apb(1, `PMX_OFS_CTRL, 32'h0000_0004);
    apb(1, `PMX_OFS_BLANK, 32'h0009_0002);
    apb(1, `PMX_OFS_EDGE, 32'h0000_0A98);
    apb(1, `PMX_OFS_CFG_BASE, 32'h7008_0112);
    tick(64);
    width(0, 0, -1);
    cmp("aux width", 32'h7, 32'(wa));
    cmp("built b width", 32'hA, 32'(wb));
    width(1, 1, -1);
    cmp("built a width", 32'hE, 32'(wa));
    width(2, 3, -1);
    cmp("aux n+3 width", 32'h7, 32'(wa));
    cmp("aux n+2 width", 32'h7, 32'(wb));
    $display("test combiner done");
    apb(1, `PMX_OFS_CTRL, 32'h0000_0018);
    tick(20);
    while (eng_cnt_i[15:0] !== 16'h000F) @(posedge clk_i);
    width(0, 0, 2);
    cmp("a cut", 32'h1, 32'(wa > 5'h00 && wa < 5'h06));
    cmp("b match", 32'(wa), 32'(wb));
    // Clock enable low must hold every PWM A and B output still
    @(posedge clk_i);
    ce_i <= 1'b0;
    #1;
    wa = 5'(pwm_out_a_o);
    wb = 5'(pwm_out_b_o);
    tick(6);
    ce_i <= 1'b1;
    #1;
    cmp("ce freeze a", 32'(wa), 32'(pwm_out_a_o));
    cmp("ce freeze b", 32'(wb), 32'(pwm_out_b_o));
    $display("test cycle limit done");
    apb(1, `PMX_OFS_SR_CFG, 32'h0010_0040);
    apb(1, `PMX_OFS_CTRL, 32'h0000_0020);
    tick(48);
    cmp("sr held", 32'h0, 32'(sr_on_time_o));
    out_nominal_i <= 1'b1;
    tick(24);
    cmp("sr rising", 32'h1, 32'(sr_on_time_o > 16'h0000
      && sr_on_time_o < 16'h0040));
    tick(96);
    cmp("sr target", 32'h40, 32'(sr_on_time_o));
    apb(1, `PMX_OFS_VIN, 32'h0000_0030);
    apb(1, `PMX_OFS_VOUT, 32'h0000_0010);
    apb(1, `PMX_OFS_CTRL, 32'h0000_00C0);
    tick(64);
    apb(0, `PMX_OFS_IDE, 32'h0);
    cmp("ide on-time", 32'h0000_2000, rd);
    $display("test rectifier done");
    results();
  end
endmodule
